//--- design/srcs_defs.svh
// constants for the sysref capture status and sync mode block
`ifndef SRCS_DEFS_SVH
`define SRCS_DEFS_SVH
`define SRCS_ADDR_PHASE 10'h129
`define SRCS_ADDR_COUNT 10'h12A
`define SRCS_ADDR_SYNC 10'h1FF
`define SRCS_ADDR_CTRL1 10'h120
`define SRCS_ADDR_TSDLY 10'h123
`define SRCS_CTRL1_CLR_BIT 6
`define SRCS_CTRL1_EDGE_BIT 3
`define SRCS_SYNC_TS_BIT 0
`define SRCS_RESET_BYTE 8'h00
`define SRCS_DIV_PHASES 5'h10
`define SRCS_DLY_MAX 8'h7F
`endif

//--- design/srcs_pkg.sv
// types for the sysref capture status and sync mode block
`default_nettype none
package srcs_pkg;
	typedef enum logic [1:0] {SRCS_OFF, SRCS_CONT, SRCS_NSHOT, SRCS_RSVD} srcs_mode_t;
	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} srcs_bus_t;
	typedef struct packed {
		logic valid;
		logic stamp;
		logic [15:0] data;
	} srcs_sample_t;
endpackage
`default_nettype wire

//--- design/srcs_delay_line.sv
// programmable sample delay line for the sysref timestamp mark
`include "srcs_defs.svh"
`default_nettype none
module srcs_delay_line
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// mark in, one per sample
	input wire logic step_in,
	input wire logic mark_in,
	input wire logic [6:0] delay_in,
	// delayed mark
	output logic mark_out
);
	logic [127:0] tap_q;
	logic [127:0] tap_d;

	always_comb
	begin
		tap_d = tap_q;
		if (step_in)
		begin
			tap_d = {tap_q[126:0], mark_in};
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			tap_q <= '0;
		end
		else
		begin
			tap_q <= tap_d;
		end
	end

	// tap 0 is the previous sample; zero delay passes the current mark straight through
	always_comb
	begin
		mark_out = (delay_in == 7'h00) ? mark_in : tap_q[delay_in - 7'h01];
	end
endmodule
`default_nettype wire

//--- design/srcs_top.sv
// sysref capture status, event counter and chip synchronization mode
//
// Contract
// - capture latches divider phase into 4-bit status
// - phase code counts half-cycle sysref lag
// - 8-bit counter increments per captured sysref
// - counter wraps at 255, no saturation
// - control-1 bit 6 clears the counter
// - sync mode 0 resets all dividers
// - divider phase change drops the link
// - timestamp mode leaves dividers untouched
// - timestamp mode ignores link and monitor
// - timestamp marks sample as output control bit
// - timestamp delayed 0 to 127 samples
//
// Added by the designer: the address-and-strobe port.
`include "srcs_defs.svh"
`default_nettype none
module srcs_top
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// register port
	input wire logic [9:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// sysref pin and capture qualifier
	input wire logic sysref_in,
	input wire logic capture_en_in,
	// sample stream
	input wire logic sample_valid_in,
	input wire logic [15:0] sample_in,
	output var srcs_pkg::srcs_sample_t sample_out,
	// divider and link
	output logic [3:0] div_phase_out,
	output logic div_reset_out,
	output logic link_drop_out,
	output logic monitor_sync_out
);
	// ----------------------------------------
	// pin synchroniser and edge detect
	// ----------------------------------------
	logic [2:0] sref_q;
	logic [2:0] sref_d;
	logic capture;

	always_comb
	begin
		sref_d = {sref_q[1:0], sysref_in};
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			sref_q <= 3'h0;
		end
		else
		begin
			sref_q <= sref_d;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	srcs_pkg::srcs_bus_t bus;
	srcs_pkg::srcs_mode_t mode_q, mode_d;
	logic edge_fall_q, edge_fall_d;
	logic ts_mode_q, ts_mode_d;
	logic [6:0] ts_delay_q, ts_delay_d;
	logic [3:0] phase_q, phase_d;
	logic [7:0] count_q, count_d;
	logic [7:0] rdata_q, rdata_d;
	logic [3:0] div_q, div_d;
	logic div_reset_q, div_reset_d;
	logic link_drop_q, link_drop_d;
	logic mon_q, mon_d;
	logic mark_pend_q, mark_pend_d;
	logic delayed_mark;
	srcs_pkg::srcs_sample_t samp_q, samp_d;

	// ----------------------------------------
	// register decode helpers
	// ----------------------------------------
	function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
		hit = (a == r);
	endfunction

	// unmapped space reads back as zero so software sees no stale data
	function automatic logic [7:0] read_mux(input logic [9:0] a, input logic [3:0] ph,
		input logic [7:0] cnt, input logic ts, input logic ef,
		input srcs_pkg::srcs_mode_t md, input logic [6:0] dly);
		unique case (a)
			`SRCS_ADDR_PHASE: read_mux = {4'h0, ph};
			`SRCS_ADDR_COUNT: read_mux = cnt;
			`SRCS_ADDR_SYNC: read_mux = {7'h00, ts};
			`SRCS_ADDR_CTRL1: read_mux = {4'h0, ef, md, 1'b0};
			`SRCS_ADDR_TSDLY: read_mux = {1'b0, dly};
			default: read_mux = 8'h00;
		endcase
	endfunction

	always_comb
	begin
		bus.addr = addr_in;
		bus.wdata = wdata_in;
		bus.wr = wr_in;
		bus.rd = rd_in;
	end

	// rising edge of sync'd sysref, in any enabled capture mode
	always_comb
	begin
		capture = sref_q[1] & ~sref_q[2] & capture_en_in & (mode_q != srcs_pkg::SRCS_OFF);
	end

	always_comb
	begin
		mode_d = mode_q;
		edge_fall_d = edge_fall_q;
		ts_mode_d = ts_mode_q;
		ts_delay_d = ts_delay_q;
		phase_d = phase_q;
		count_d = count_q;
		rdata_d = 8'h00;
		if (bus.wr && hit(bus.addr, `SRCS_ADDR_CTRL1))
		begin
			mode_d = srcs_pkg::srcs_mode_t'(bus.wdata[2:1]);
			// edge select only takes effect while capture is disabled
			if (mode_q == srcs_pkg::SRCS_OFF)
			begin
				edge_fall_d = bus.wdata[`SRCS_CTRL1_EDGE_BIT];
			end
		end
		if (bus.wr && hit(bus.addr, `SRCS_ADDR_SYNC))
		begin
			ts_mode_d = bus.wdata[`SRCS_SYNC_TS_BIT];
		end
		if (bus.wr && hit(bus.addr, `SRCS_ADDR_TSDLY))
		begin
			ts_delay_d = bus.wdata[6:0];
		end
		if (capture)
		begin
			// half-cycle lag code, edge select adds the half
			phase_d = {div_q[2:0], edge_fall_q};
			count_d = count_q + 8'h01;
		end
		// capture wins over a clear in the same cycle
		if (bus.wr && hit(bus.addr, `SRCS_ADDR_CTRL1) && bus.wdata[`SRCS_CTRL1_CLR_BIT]
			&& !capture)
		begin
			count_d = `SRCS_RESET_BYTE;
		end
		if (bus.rd)
		begin
			rdata_d = read_mux(bus.addr, phase_q, count_q, ts_mode_q, edge_fall_q, mode_q,
				ts_delay_q);
		end
	end

	// ----------------------------------------
	// divider, link and monitor effects
	// ----------------------------------------
	always_comb
	begin
		div_d = div_q + 4'h1;
		div_reset_d = 1'b0;
		link_drop_d = 1'b0;
		mon_d = 1'b0;
		mark_pend_d = 1'b0;
		if (capture && !ts_mode_q)
		begin
			div_d = 4'h0;
			div_reset_d = 1'b1;
			mon_d = 1'b1;
			// a reset landing on phase zero moves nothing, so the link stays up
			link_drop_d = (div_q != 4'h0);
		end
		if (capture && ts_mode_q)
		begin
			mark_pend_d = 1'b1;
		end
		if (mark_pend_q && !sample_valid_in)
		begin
			mark_pend_d = 1'b1;
		end
	end

	// ----------------------------------------
	// sample stream
	// ----------------------------------------
	// an idle cycle keeps the last sample and its stamp; valid says which counts
	always_comb
	begin
		samp_d = samp_q;
		samp_d.valid = sample_valid_in;
		if (sample_valid_in)
		begin
			samp_d.data = sample_in;
			samp_d.stamp = delayed_mark;
		end
	end

	// ----------------------------------------
	// timestamp delay
	// ----------------------------------------
	// marks advance once per valid sample, so the delay counts samples

	srcs_delay_line u_delay
	(
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.step_in(sample_valid_in),
		.mark_in(mark_pend_q),
		.delay_in(ts_delay_q),
		.mark_out(delayed_mark)
	);

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	// rdata falls back to zero whenever no read is pending
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			mode_q <= srcs_pkg::SRCS_OFF;
			edge_fall_q <= 1'b0;
			ts_mode_q <= 1'b0;
			ts_delay_q <= 7'h00;
			phase_q <= 4'h0;
			count_q <= 8'h00;
			rdata_q <= 8'h00;
		end
		else
		begin
			mode_q <= mode_d;
			edge_fall_q <= edge_fall_d;
			ts_mode_q <= ts_mode_d;
			ts_delay_q <= ts_delay_d;
			phase_q <= phase_d;
			count_q <= count_d;
			rdata_q <= rdata_d;
		end
	end

	// divider keeps running through a link drop; only a capture re-phases it
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			div_q <= 4'h0;
			div_reset_q <= 1'b0;
			link_drop_q <= 1'b0;
			mon_q <= 1'b0;
			mark_pend_q <= 1'b0;
		end
		else
		begin
			div_q <= div_d;
			div_reset_q <= div_reset_d;
			link_drop_q <= link_drop_d;
			mon_q <= mon_d;
			mark_pend_q <= mark_pend_d;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			samp_q <= '0;
		end
		else
		begin
			samp_q <= samp_d;
		end
	end

	always_comb
	begin
		rdata_out = rdata_q;
		sample_out = samp_q;
		div_phase_out = div_q;
		div_reset_out = div_reset_q;
		link_drop_out = link_drop_q;
		monitor_sync_out = mon_q;
	end
endmodule
`default_nettype wire

//--- verification/srcs_chk.sv
// assertions for srcs_top
`default_nettype none
module srcs_chk
(
	// bus
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic [9:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	// sysref
	input wire logic sysref_in,
	input wire logic capture_en_in,
	// results
	input wire srcs_pkg::srcs_sample_t sample_out,
	input wire logic [3:0] div_phase_out,
	input wire logic div_reset_out,
	input wire logic link_drop_out,
	input wire logic monitor_sync_out
);
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (!nrst_in);
	// capture mode in [2:1], timestamp bit in [0]
	logic [2:0] m_q;
	always_ff @(posedge sys_clk_in or negedge nrst_in)
		if (!nrst_in)
			m_q <= 3'h0;
		else if (wr_in && addr_in == 10'h120)
			m_q[2:1] <= wdata_in[2:1];
		else if (wr_in && addr_in == 10'h1FF)
			m_q[0] <= wdata_in[0];
	sequence s_sync_edge;
		$rose(sysref_in) && capture_en_in && m_q == 3'h2;
	endsequence
	chk_sync_reset: assert property (s_sync_edge |-> ##[2:4] div_reset_out)
		else $error("no reset");
	chk_ts_quiet: assert property (m_q[0] |-> !(div_reset_out || link_drop_out))
		else $error("ts reset");
	chk_ts_monitor: assert property (m_q[0] |-> !monitor_sync_out)
		else $error("ts monitor");
	chk_drop_cause: assert property (link_drop_out |-> div_reset_out)
		else $error("lone drop");
	chk_mon_pair: assert property (monitor_sync_out |-> div_reset_out)
		else $error("lone monitor");
	chk_reset_once: assert property (div_reset_out |=> !div_reset_out)
		else $error("long reset");
	chk_needs_en: assert property (div_reset_out |-> $past(capture_en_in))
		else $error("no enable");
	chk_stamp_ts: assert property (sample_out.stamp |-> m_q[0])
		else $error("stray stamp");
	chk_div_zero: assert property (div_reset_out |-> div_phase_out == 4'h0)
		else $error("divider not realigned");
endmodule
bind srcs_top srcs_chk chk(.*);
`default_nettype wire

//--- verification/srcs_sref_gen.sv
// sysref source: one rise every ten cycles while enabled
`default_nettype none
module srcs_sref_gen
(
	// clock and enable
	input wire logic sys_clk_in,
	input wire logic go_in,
	// sysref pin
	output logic sysref_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] n_q = 4'h0;
	always @(posedge sys_clk_in)
		n_q <= (go_in && n_q < 4'h9) ? n_q + 4'h1 : 4'h0;
	assign sysref_out = go_in && n_q < 4'h5;
endmodule
`default_nettype wire

//--- verification/testbench.sv
// bench for srcs_top
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_in, nrst_in, wr_in, rd_in, capture_en_in, go, sysref_in;
	logic [9:0] addr_in;
	logic [7:0] wdata_in, rdata_out, v;
	logic [15:0] sample_in = 16'h0000;
	logic sample_valid_in = 1'h1, tgl = 1'h0;
	logic [7:0] ph;
	srcs_pkg::srcs_sample_t sample_out;
	int err_total = 0, comparisons = 0, stamps = 0;
	// address beside reset value; the last is unmapped
	logic [17:0] rows [4] = '{18'h12900, 18'h12A00, 18'h1FF00, 18'h3FF00};
	srcs_top dut(.*, .div_phase_out(), .div_reset_out(), .link_drop_out(),
		.monitor_sync_out());
	srcs_sref_gen pm(.sys_clk_in, .go_in(go), .sysref_out(sysref_in));
	initial
	begin
		sys_clk_in = 1'h0;
		forever #20 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in)
	begin
		sample_in <= sample_in + 16'h1;
		sample_valid_in <= tgl ? !sample_valid_in : 1'h1;
	end
	// counted away from the launching edge, valid samples only
	always @(negedge sys_clk_in)
		stamps += (sample_out.valid === 1'h1) && (sample_out.stamp === 1'h1);
	task automatic check(input logic [7:0] seen, exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		{wr_in, rd_in, addr_in, wdata_in} <= {w, !w, a, d};
		@(posedge sys_clk_in);
		{wr_in, rd_in} <= 2'h0;
		#1 v = rdata_out;
	endtask
	// n sysref rises, then the count is read with capture off
	task automatic run(input int n);
		bus(1'h1, 10'h120, 8'h02);
		go <= 1'h1;
		repeat (n * 10) @(posedge sys_clk_in);
		go <= 1'h0;
		repeat (12) @(posedge sys_clk_in);
		bus(1'h1, 10'h120, 8'h00);
		bus(1'h0, 10'h12A, 8'h00);
	endtask
	task automatic summarize();
		if (err_total == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		{nrst_in, wr_in, rd_in, go, capture_en_in, addr_in, wdata_in} = '0;
		repeat (8) @(posedge sys_clk_in);
		nrst_in <= 1'h1;
		foreach (rows[i])
		begin
			bus(1'h0, rows[i][17:8], 8'h00);
			check(v, rows[i][7:0]);
		end
		capture_en_in <= 1'h1;
		run(257);
		check(v, 8'h01);
		bus(1'h0, 10'h129, 8'h00);
		ph = v;
		check(ph & 8'hF1, 8'h00);
		bus(1'h1, 10'h120, 8'h40);
		capture_en_in <= 1'h0;
		run(2);
		check(v, 8'h00);
		bus(1'h0, 10'h129, 8'h00);
		check(v, ph);
		bus(1'h1, 10'h120, 8'h0A);
		bus(1'h1, 10'h120, 8'h02);
		bus(1'h0, 10'h120, 8'h00);
		check(v, 8'h0A);
		bus(1'h1, 10'h120, 8'h00);
		bus(1'h0, 10'h120, 8'h00);
		check(v, 8'h08);
		@(posedge sys_clk_in);
		#1 check(sample_out.data[7:0], sample_in[7:0] - 8'h01);
		check({7'h00, sample_out.valid}, 8'h01);
		tgl <= 1'h1;
		capture_en_in <= 1'h1;
		bus(1'h1, 10'h1FF, 8'h01);
		bus(1'h1, 10'h123, 8'h03);
		run(3);
		check(v, 8'h03);
		check(8'(stamps), 8'h03);
		nrst_in <= 1'h0;
		@(posedge sys_clk_in);
		nrst_in <= 1'h1;
		bus(1'h0, 10'h12A, 8'h00);
		check(v, 8'h00);
		bus(1'h0, 10'h1FF, 8'h00);
		check(v, 8'h00);
		summarize();
	end
	// run takes under 3000 cycles
	initial
	begin
		#200000;
		err_total++;
		summarize();
	end
endmodule
`default_nettype wire
